// ==== cbmc_cfg.svh ====
// Constants for the capture buffer mode control block.
`ifndef CBMC_CFG_SVH
`define CBMC_CFG_SVH
`define CBMC_DEPTH_MAX      1024
`define CBMC_ADDR_W         10
`define CBMC_DEPTH_256      11'h0100
`define CBMC_DEPTH_512      11'h0200
`define CBMC_DEPTH_1K       11'h0400
`define CBMC_PAT_LOW        8'h00
`define CBMC_PAT_HIGH       8'hFF
`define CBMC_MULT_X1        2'b00
`define CBMC_MULT_X2        2'b01
`define CBMC_MULT_X4        2'b10
`define CBMC_MULT_X8        2'b11
`define CBMC_FACTOR_X1      4'h1
`define CBMC_FACTOR_X2      4'h2
`define CBMC_FACTOR_X4      4'h4
`define CBMC_FACTOR_X8      4'h8
`endif

// ==== cbmc_pkg.sv ====
// Types for the capture buffer mode control block.
package cbmc_pkg;
  typedef enum logic [1:0] {CbmcOff, CbmcSleep, CbmcActive} cbmc_power_t;
  typedef enum logic [1:0] {CbmcIdle, CbmcWrite, CbmcRead} cbmc_op_t;
endpackage

// ==== cbmc_rd_if.sv ====
// Signals between the sample-clock core and the readout-clock side.
`timescale 1ns/10ps
interface cbmc_rd_if;
  logic [10:0] wrCountGray;
  logic [10:0] rdCountGray;
  logic        readOn;
  logic        testOn;
  logic        edgeHigh;
  logic        capToggle;
  logic        capAck;
  logic [9:0]  rdAddr;
  logic [7:0]  rdData;
  modport core (input rdCountGray, input capAck, input rdAddr, output wrCountGray,
                output readOn, output testOn, output edgeHigh, output capToggle,
                output rdData);
  modport reader (output rdCountGray, output capAck, output rdAddr, input wrCountGray,
                  input readOn, input testOn, input edgeHigh, input capToggle,
                  input rdData);
endinterface

// ==== cbmc_readout.sv ====
// Readout-clock side: read pointer, test pattern and data strobe.
`timescale 1ns/10ps
`include "cbmc_cfg.svh"
module cbmc_readout
  import cbmc_pkg::*;
(
  // Readout clock
  input  wire logic  rdClk,
  input  wire logic  rst,
  // Core link
  cbmc_rd_if.reader  link,
  // Output pins
  output logic [7:0] rdOut,
  output logic       rdStrobe,
  output logic       rdValid
);
  logic [2:0]  onSync_q, testSync_q, edgeSync_q, capSync_q;
  logic [2:0]  onSync_d, testSync_d, edgeSync_d, capSync_d;
  logic [10:0] wrG1_q, wrG2_q, wrG1_d, wrG2_d;
  logic [10:0] rdCnt_q, rdCnt_d;
  logic        capSeen_q, capSeen_d;
  logic        pat_q, pat_d;
  logic [7:0]  out_q, out_d;
  logic        strobe_q, strobe_d;
  logic        valid_q, valid_d;
  logic [10:0] wrBin;
  logic        avail;

  function automatic logic [10:0] gray2bin(input logic [10:0] g);
    logic [10:0] b;
    b = '0;
    for (int i = 10; i >= 0; i--)
    begin
      b[i] = g[i] ^ ((i == 10) ? 1'b0 : b[i + 1]);
    end
    return b;
  endfunction

  assign wrBin = gray2bin(wrG2_q);
  assign avail = (wrBin != rdCnt_q);

  always_comb
  begin
    onSync_d   = {onSync_q[1:0], link.readOn};
    testSync_d = {testSync_q[1:0], link.testOn};
    edgeSync_d = {edgeSync_q[1:0], link.edgeHigh};
    capSync_d  = {capSync_q[1:0], link.capToggle};
    wrG1_d     = link.wrCountGray;
    wrG2_d     = wrG1_q;
    rdCnt_d    = rdCnt_q;
    capSeen_d  = capSeen_q;
    pat_d      = pat_q;
    out_d      = out_q;
    strobe_d   = !edgeSync_q[2];
    valid_d    = 1'b0;
    if (capSync_q[2] == capSync_q[1] && capSeen_q != capSync_q[2])
    begin
      capSeen_d = capSync_q[2];
      rdCnt_d   = '0;
    end
    else if (testSync_q[2] && testSync_q[1])
    begin
      // Pattern ignores the pointers so training works at any time.
      pat_d    = !pat_q;
      out_d    = pat_q ? `CBMC_PAT_HIGH : `CBMC_PAT_LOW;
      strobe_d = !strobe_q;
      valid_d  = 1'b1;
    end
    else if (onSync_q[2] && onSync_q[1] && avail)
    begin
      rdCnt_d  = rdCnt_q + 11'h0001;
      out_d    = link.rdData;
      strobe_d = !strobe_q;
      valid_d  = 1'b1;
    end
    else
    begin
      out_d = edgeSync_q[2] ? 8'h00 : 8'hFF;
    end
  end

  always_ff @(posedge rdClk)
  begin
    if (rst)
    begin
      onSync_q <= '0; testSync_q <= '0; edgeSync_q <= '1; capSync_q <= '0;
      wrG1_q <= '0; wrG2_q <= '0; rdCnt_q <= '0; capSeen_q <= 1'b0;
      pat_q <= 1'b0; out_q <= '0; strobe_q <= 1'b0; valid_q <= 1'b0;
    end
    else
    begin
      onSync_q <= onSync_d; testSync_q <= testSync_d; edgeSync_q <= edgeSync_d;
      capSync_q <= capSync_d; wrG1_q <= wrG1_d; wrG2_q <= wrG2_d;
      rdCnt_q <= rdCnt_d; capSeen_q <= capSeen_d; pat_q <= pat_d;
      out_q <= out_d; strobe_q <= strobe_d; valid_q <= valid_d;
    end
  end

  assign link.rdCountGray = rdCnt_q ^ (rdCnt_q >> 1);
  assign link.capAck      = capSeen_q;
  assign link.rdAddr      = rdCnt_d[9:0];
  assign rdOut            = out_q;
  assign rdStrobe         = strobe_q;
  assign rdValid          = valid_q;
endmodule

// ==== capture_buffer_mode_control.sv ====
// Mode decode and capture buffer control on the sample clock.
`timescale 1ns/10ps
`include "cbmc_cfg.svh"
// Summary of operation
// - Full shutdown overrides all but the multiplier decode, device stopped.
// - Converter sleep: no capture, buffer still readable.
// - Read enable alone shifts buffer out on readout.
// - All low: bypass drives samples, else idle.
// - Write enable captures samples, read enable ignored.
// - Depth code zero bypasses the buffer entirely.
// - Capture depth 256, 512 or 1k bytes.
// - Readout depth follows the same depth code.
// - Mid level on edge/test input selects test.
// - Floating edge/test input reads as high.
// - Test pattern needs the readout clock running.
// - Test pattern alternates 00h and FFh.
// - Auto-stop halts writing once depth filled.
// - Full flag rises at configured depth.
// - Edge select high: strobe rests low, toggles once per word.
// - Multiplier code 10 selects times four.
// - Without auto-stop, writing wraps and overwrites.
// - Empty flag high after reset or full readout.
// - Write enable restarts pointers and new capture.
// - Bypass ignores write/read enables, both flags held low.
module capture_buffer_mode_control
  import cbmc_pkg::*;
#(
  parameter int DEPTH = `CBMC_DEPTH_MAX
)
(
  // Clocks and reset
  input  wire logic       clk_sys,
  input  wire logic       rdClk,
  input  wire logic       rst,
  // Mode pins
  input  wire logic       fullShutdown,
  input  wire logic       converterSleep,
  input  wire logic       writeEnable,
  input  wire logic       readEnable,
  input  wire logic       depthSelectLow,
  input  wire logic       depthSelectHigh,
  input  wire logic       autoStopOnFull,
  input  wire logic       pllFactorSelectLow,
  input  wire logic       pllFactorSelectHigh,
  // Edge/test select: pad comparators report low and mid level
  input  wire logic       edgeTestIsMid,
  input  wire logic       edgeTestIsLow,
  // Converter samples
  input  wire logic [7:0] sampleIn,
  // Outputs
  output logic [7:0]      dataOut,
  output logic            outputDataStrobe,
  output logic            fullFlag,
  output logic            emptyFlag,
  output logic            converterPowered,
  output logic [3:0]      pllFactor
);
  cbmc_rd_if link();

  logic [7:0]  mem [DEPTH];
  logic [2:0]  wenSync_q, renSync_q, midSync_q, lowSync_q, capAckSync_q;
  logic [2:0]  wenSync_d, renSync_d, midSync_d, lowSync_d, capAckSync_d;
  logic [10:0] rdG1_q, rdG2_q, rdG1_d, rdG2_d;
  logic [10:0] wrCnt_q, wrCnt_d;
  logic        filled_q, filled_d;
  logic        wenLvl_q, renLvl_q, midLvl_q, lowLvl_q;
  logic        wenLvl_d, renLvl_d, midLvl_d, lowLvl_d;
  logic        capTog_q, capTog_d;
  logic        full_q, full_d;
  logic        empty_q, empty_d;
  logic        wenPrev_q, wenPrev_d;
  logic [7:0]  byp_q, byp_d;
  logic        bypStb_q, bypStb_d;
  logic [7:0]  rdData_q;
  logic [10:0] depth;
  logic [10:0] rdBin;
  logic        bypass, wenEff, renEff, testOn, edgeHigh, writeNow, ackMatch;
  logic [7:0]  rdOut;
  logic        rdStrobe, rdValid;
  cbmc_power_t power;
  cbmc_op_t    op;

  function automatic logic [10:0] depthOf(input logic hi, input logic lo);
    case ({hi, lo})
      2'b01:   depthOf = `CBMC_DEPTH_256;
      2'b10:   depthOf = `CBMC_DEPTH_512;
      2'b11:   depthOf = `CBMC_DEPTH_1K;
      default: depthOf = 11'h000;
    endcase
  endfunction

  function automatic logic [10:0] g2b(input logic [10:0] g);
    logic [10:0] b;
    b = '0;
    for (int i = 10; i >= 0; i--)
    begin
      b[i] = g[i] ^ ((i == 10) ? 1'b0 : b[i + 1]);
    end
    return b;
  endfunction

  // A synchronised level only moves once the last two stages agree.
  function automatic logic settle(input logic [2:0] s, input logic cur);
    settle = (s[2] == s[1]) ? s[2] : cur;
  endfunction

  always_comb
  begin
    case ({pllFactorSelectHigh, pllFactorSelectLow})
      `CBMC_MULT_X1: pllFactor = `CBMC_FACTOR_X1;
      `CBMC_MULT_X2: pllFactor = `CBMC_FACTOR_X2;
      `CBMC_MULT_X4: pllFactor = `CBMC_FACTOR_X4;
      default:       pllFactor = `CBMC_FACTOR_X8;
    endcase
  end

  assign depth    = depthOf(depthSelectHigh, depthSelectLow);
  assign bypass   = (depth == 11'h000);
  // A floating pin is pulled up and reads neither low nor mid.
  assign testOn   = midLvl_q;
  assign edgeHigh = !(lowLvl_q || testOn);
  assign rdBin    = g2b(rdG2_q);
  // The read count is trusted only once the reader has seen the new capture.
  assign ackMatch = (capAckSync_q[2] == capAckSync_q[1]) && (capAckSync_q[2] == capTog_q);

  always_comb
  begin
    if (fullShutdown)
    begin
      power = CbmcOff;
    end
    else if (converterSleep)
    begin
      power = CbmcSleep;
    end
    else
    begin
      power = CbmcActive;
    end
  end

  assign wenEff = (power == CbmcActive) && wenLvl_q && !bypass;
  assign renEff = (power != CbmcOff) && !wenEff && renLvl_q && !bypass;

  always_comb
  begin
    case (power)
      CbmcActive: op = wenEff ? CbmcWrite : (renEff ? CbmcRead : CbmcIdle);
      CbmcSleep:  op = renEff ? CbmcRead : CbmcIdle;
      default:    op = CbmcIdle;
    endcase
  end

  assign writeNow = (op == CbmcWrite) && !(autoStopOnFull && full_q);

  always_comb
  begin
    wenSync_d    = {wenSync_q[1:0], writeEnable};
    renSync_d    = {renSync_q[1:0], readEnable};
    midSync_d    = {midSync_q[1:0], edgeTestIsMid};
    lowSync_d    = {lowSync_q[1:0], edgeTestIsLow};
    capAckSync_d = {capAckSync_q[1:0], link.capAck};
    wenLvl_d     = settle(wenSync_q, wenLvl_q);
    renLvl_d     = settle(renSync_q, renLvl_q);
    midLvl_d     = settle(midSync_q, midLvl_q);
    lowLvl_d     = settle(lowSync_q, lowLvl_q);
    rdG1_d       = link.rdCountGray;
    rdG2_d       = rdG1_q;
    wrCnt_d      = wrCnt_q;
    filled_d     = filled_q;
    capTog_d     = capTog_q;
    full_d       = full_q;
    empty_d      = empty_q;
    wenPrev_d    = wenEff;
    byp_d        = byp_q;
    bypStb_d     = !edgeHigh;
    if (bypass || power == CbmcOff)
    begin
      full_d  = 1'b0;
      empty_d = 1'b0;
      if (bypass && power == CbmcActive)
      begin
        byp_d    = sampleIn;
        bypStb_d = !bypStb_q;
      end
    end
    else
    begin
      if (wenEff && !wenPrev_q)
      begin
        wrCnt_d  = 11'h000;
        capTog_d = !capTog_q;
        full_d   = 1'b0;
        filled_d = 1'b0;
      end
      else if (writeNow)
      begin
        wrCnt_d = wrCnt_q + 11'h0001;
        empty_d = 1'b0;
        if (wrCnt_q + 11'h0001 >= depth)
        begin
          full_d   = 1'b1;
          filled_d = 1'b1;
        end
      end
      if (!wenEff && renEff && ackMatch && rdBin != 11'h000)
      begin
        full_d = 1'b0;
      end
      if (!wenEff && filled_q && ackMatch && rdBin == depth)
      begin
        empty_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      wenSync_q <= '0; renSync_q <= '0; midSync_q <= '0; lowSync_q <= '0;
      capAckSync_q <= '0; rdG1_q <= '0; rdG2_q <= '0; wrCnt_q <= '0;
      filled_q <= 1'b0; capTog_q <= 1'b0; full_q <= 1'b0; empty_q <= 1'b1;
      wenLvl_q <= 1'b0; renLvl_q <= 1'b0; midLvl_q <= 1'b0; lowLvl_q <= 1'b0;
      wenPrev_q <= 1'b0; byp_q <= '0; bypStb_q <= 1'b0;
    end
    else
    begin
      wenSync_q <= wenSync_d; renSync_q <= renSync_d; midSync_q <= midSync_d;
      lowSync_q <= lowSync_d; capAckSync_q <= capAckSync_d;
      rdG1_q <= rdG1_d; rdG2_q <= rdG2_d; wrCnt_q <= wrCnt_d; filled_q <= filled_d;
      wenLvl_q <= wenLvl_d; renLvl_q <= renLvl_d; midLvl_q <= midLvl_d; lowLvl_q <= lowLvl_d;
      capTog_q <= capTog_d; full_q <= full_d; empty_q <= empty_d;
      wenPrev_q <= wenPrev_d; byp_q <= byp_d; bypStb_q <= bypStb_d;
    end
  end

  // Buffer wraps within the configured depth.
  always_ff @(posedge clk_sys)
  begin
    if (writeNow && !(wenEff && !wenPrev_q))
    begin
      mem[10'(wrCnt_q & (depth - 11'h001))] <= sampleIn;
    end
  end

  always_ff @(posedge rdClk)
  begin
    rdData_q <= mem[link.rdAddr];
  end

  // The readable end only moves between captures, so it is static while read.
  assign link.wrCountGray = filled_q ? (depth ^ (depth >> 1)) : 11'h000;
  assign link.readOn      = (op == CbmcRead) && filled_q;
  assign link.testOn      = testOn && power != CbmcOff;
  assign link.edgeHigh    = edgeHigh;
  assign link.capToggle   = capTog_q;
  assign link.rdData      = rdData_q;

  cbmc_readout i_cbmc_readout
  (
    .rdClk    (rdClk),
    .rst      (rst),
    .link     (link.reader),
    .rdOut    (rdOut),
    .rdStrobe (rdStrobe),
    .rdValid  (rdValid)
  );

  always_comb
  begin
    if (power == CbmcOff)
    begin
      dataOut          = 8'h00;
      outputDataStrobe = 1'b0;
    end
    else if (bypass && !testOn)
    begin
      dataOut          = byp_q;
      outputDataStrobe = bypStb_q;
    end
    else
    begin
      dataOut          = rdOut;
      outputDataStrobe = rdStrobe;
    end
  end

  assign fullFlag         = full_q;
  assign emptyFlag        = empty_q;
  assign converterPowered = (power == CbmcActive);
endmodule

// ==== cbmc_props.sv ====
// Port assertions for the capture buffer mode control block.
`timescale 1ns/10ps
module cbmc_props
#(
  parameter int DEPTH = 1024
)
(
  // Clocks and reset
  input wire logic       clk_sys,
  input wire logic       rdClk,
  input wire logic       rst,
  // Mode pins
  input wire logic       fullShutdown,
  input wire logic       converterSleep,
  input wire logic       writeEnable,
  input wire logic       depthSelectLow,
  input wire logic       depthSelectHigh,
  input wire logic       pllFactorSelectLow,
  input wire logic       pllFactorSelectHigh,
  input wire logic       edgeTestIsMid,
  // Outputs
  input wire logic [7:0] dataOut,
  input wire logic       fullFlag,
  input wire logic       emptyFlag,
  input wire logic       converterPowered,
  input wire logic [3:0] pllFactor
);
  // ==========================================================
  // Sequences and properties
  sequence s_bypass;
    (!rst && !depthSelectLow && !depthSelectHigh) [*6];
  endsequence
  sequence s_asleep;
    (!rst && converterSleep) [*8];
  endsequence
  sequence s_test;
    (!rst && edgeTestIsMid) [*8];
  endsequence
  property p_shut;
    @(posedge clk_sys) disable iff (rst) fullShutdown |-> !converterPowered;
  endproperty
  a_shut: assert property (p_shut)
    else $error("converter powered in shutdown");
  property p_sleep;
    @(posedge clk_sys) disable iff (rst) converterSleep |-> !converterPowered;
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("converter powered in sleep");
  property p_pll;
    @(posedge clk_sys) disable iff (rst)
      (pllFactorSelectHigh && !pllFactorSelectLow) |-> pllFactor == 4'h4;
  endproperty
  a_pll: assert property (p_pll)
    else $error("multiplier code 10 not four");
  property p_bypass;
    @(posedge clk_sys) disable iff (rst) s_bypass |-> !fullFlag && !emptyFlag;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("flag high in bypass");
  property p_full;
    @(posedge clk_sys) disable iff (rst)
      $rose(fullFlag) |-> !emptyFlag && $past(writeEnable, 4);
  endproperty
  a_full: assert property (p_full)
    else $error("full flag without capture");
  property p_nowrite;
    @(posedge clk_sys) disable iff (rst) s_asleep |-> !$fell(emptyFlag);
  endproperty
  a_nowrite: assert property (p_nowrite)
    else $error("byte written while asleep");
  property p_rstflags;
    @(posedge clk_sys) disable iff (rst)
      $fell(rst) && (depthSelectLow || depthSelectHigh) |-> emptyFlag && !fullFlag;
  endproperty
  a_rstflags: assert property (p_rstflags)
    else $error("flags wrong after reset");
  property p_test;
    @(posedge rdClk) disable iff (rst)
      s_test |-> (dataOut == 8'h00 || dataOut == 8'hFF) ##1 dataOut == ~$past(dataOut);
  endproperty
  a_test: assert property (p_test)
    else $error("test pattern not alternating");
endmodule
bind capture_buffer_mode_control cbmc_props #(.DEPTH(DEPTH)) i_cbmc_props (
  .clk_sys(clk_sys), .rdClk(rdClk), .rst(rst), .fullShutdown(fullShutdown),
  .converterSleep(converterSleep), .writeEnable(writeEnable),
  .depthSelectLow(depthSelectLow), .depthSelectHigh(depthSelectHigh),
  .pllFactorSelectLow(pllFactorSelectLow), .pllFactorSelectHigh(pllFactorSelectHigh),
  .edgeTestIsMid(edgeTestIsMid), .dataOut(dataOut), .fullFlag(fullFlag),
  .emptyFlag(emptyFlag), .converterPowered(converterPowered), .pllFactor(pllFactor));

// ==== cbmc_reader_model.sv ====
// Behavioural model of the logic that reads captured bytes.
`timescale 1ns/10ps
module cbmc_reader_model
(
  // Bench control
  input  wire logic       runClk,
  input  wire logic       clear,
  // Device pins
  input  wire logic [7:0] dataOut,
  input  wire logic       outputDataStrobe,
  output logic            rdClk,
  // Observations
  output int              byteCount,
  output int              incErrs,
  output int              altErrs
);
  logic [7:0] lastByte;
  // ==========================================================
  // Readout clock runs only inside a frame and rests low between.
  initial
  begin
    rdClk = 1'b0;
    #7;
    forever
    begin
      #62.5;
      rdClk = runClk ? ~rdClk : 1'b0;
    end
  end
  // Each strobe change marks one word; it is taken once settled.
  always @(outputDataStrobe or posedge clear)
  begin
    if (clear)
    begin
      byteCount = 0;
      incErrs = 0;
      altErrs = 0;
    end
    else if (runClk)
    begin
      #20;
      if (byteCount > 0 && dataOut !== lastByte + 8'h01)
        incErrs++;
      if (byteCount > 0 && dataOut !== ~lastByte)
        altErrs++;
      lastByte = dataOut;
      byteCount++;
    end
  end
endmodule

// ==== tb_top.sv ====
// Self-checking bench for the capture buffer mode control block.
`timescale 1ns/10ps
module tb_top;
  logic       clk_sys, rdClk, rst, fullShutdown, converterSleep, writeEnable;
  logic       readEnable, depthSelectLow, depthSelectHigh, autoStopOnFull;
  logic       pllFactorSelectLow, pllFactorSelectHigh, edgeTestIsMid, edgeTestIsLow;
  logic       countOn, runClk, clear, outputDataStrobe, fullFlag, emptyFlag;
  logic       converterPowered;
  logic [7:0] sampleIn, fixedSample, dataOut;
  logic [3:0] pllFactor;
  int         byteCount, incErrs, altErrs, fails, checked;
  // ==========================================================
  // Instances, clock and converter samples
  capture_buffer_mode_control #(.DEPTH(1024)) i_capture_buffer_mode_control (
    .clk_sys(clk_sys), .rdClk(rdClk), .rst(rst), .fullShutdown(fullShutdown),
    .converterSleep(converterSleep), .writeEnable(writeEnable), .readEnable(readEnable),
    .depthSelectLow(depthSelectLow), .depthSelectHigh(depthSelectHigh),
    .autoStopOnFull(autoStopOnFull), .pllFactorSelectLow(pllFactorSelectLow),
    .pllFactorSelectHigh(pllFactorSelectHigh), .edgeTestIsMid(edgeTestIsMid),
    .edgeTestIsLow(edgeTestIsLow), .sampleIn(sampleIn), .dataOut(dataOut),
    .outputDataStrobe(outputDataStrobe), .fullFlag(fullFlag), .emptyFlag(emptyFlag),
    .converterPowered(converterPowered), .pllFactor(pllFactor));
  cbmc_reader_model i_cbmc_reader_model (.runClk(runClk), .clear(clear),
    .dataOut(dataOut), .outputDataStrobe(outputDataStrobe), .rdClk(rdClk),
    .byteCount(byteCount), .incErrs(incErrs), .altErrs(altErrs));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
    sampleIn <= countOn ? sampleIn + 8'h01 : fixedSample;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_bypass;
    {depthSelectHigh, depthSelectLow} <= 2'b00;
    {writeEnable, readEnable} <= 2'b11;
    fixedSample <= 8'h5A;
    tick(20);
    check(dataOut === 8'h5A, "bypass data");
    check(fullFlag === 1'b0 && emptyFlag === 1'b0, "bypass flags");
    {writeEnable, readEnable} <= 2'b00;
    fixedSample <= 8'hA5;
    tick(20);
    check(dataOut === 8'hA5, "idle bypass data");
    $display("bypass test ended");
  endtask
  task automatic t_capture(input logic [1:0] code, input logic auto, input int depth,
                           input int again);
    int n;
    {depthSelectHigh, depthSelectLow} <= code;
    autoStopOnFull <= auto;
    countOn <= 1'b1;
    for (int pass = 0; pass <= again; pass++)
    begin
      writeEnable <= 1'b1;
      for (n = 0; n < depth + 40 && fullFlag !== 1'b1; n++)
        tick(1);
      check(fullFlag === 1'b1 && emptyFlag === 1'b0, "buffer not full");
      tick(100);
      check(fullFlag === 1'b1, "full flag lost");
      writeEnable <= 1'b0;
      readEnable <= 1'b1;
      clear <= 1'b1;
      runClk <= 1'b1;
      tick(1);
      clear <= 1'b0;
      if (pass < again)
        tick(200);
      if (pass < again)
        check(fullFlag === 1'b0 && byteCount > 0, "read not started");
    end
    for (n = 0; n < (depth + 40) * 6 && emptyFlag !== 1'b1; n++)
      tick(1);
    runClk <= 1'b0;
    readEnable <= 1'b0;
    countOn <= 1'b0;
    check(emptyFlag === 1'b1 && byteCount == depth, "read length");
    check(incErrs == 0, "read order");
    $display("capture test of %0d bytes ended", depth);
  endtask
  task automatic t_sleep;
    {depthSelectHigh, depthSelectLow} <= 2'b01;
    converterSleep <= 1'b1;
    tick(10);
    writeEnable <= 1'b1;
    tick(400);
    check(emptyFlag === 1'b1 && fullFlag === 1'b0, "write taken asleep");
    check(converterPowered === 1'b0, "converter awake");
    converterSleep <= 1'b0;
    fullShutdown <= 1'b1;
    writeEnable <= 1'b0;
    tick(10);
    check(converterPowered === 1'b0, "converter awake in shutdown");
    fullShutdown <= 1'b0;
    tick(10);
    check(converterPowered === 1'b1, "converter not restored");
    $display("sleep test ended");
  endtask
  task automatic t_test;
    edgeTestIsMid <= 1'b1;
    runClk <= 1'b1;
    tick(100);
    clear <= 1'b1;
    tick(1);
    clear <= 1'b0;
    tick(200);
    check(byteCount > 30 && altErrs == 0, "test pattern");
    edgeTestIsMid <= 1'b0;
    edgeTestIsLow <= 1'b1;
    tick(60);
    check(outputDataStrobe === 1'b1 && dataOut === 8'hFF, "idle level, edge low");
    edgeTestIsLow <= 1'b0;
    tick(60);
    check(outputDataStrobe === 1'b0 && dataOut === 8'h00, "idle level, floating");
    runClk <= 1'b0;
    $display("test pattern test ended");
  endtask
  task automatic t_pll;
    for (int c = 0; c < 4; c++)
    begin
      {pllFactorSelectHigh, pllFactorSelectLow} <= c[1:0];
      tick(2);
      check(pllFactor === (4'h1 << c), "multiplier");
    end
    $display("multiplier test ended");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial
  begin
    fails = 0;
    checked = 0;
    {rst, depthSelectLow, runClk} = 3'b111;
    {fullShutdown, converterSleep, writeEnable, readEnable, depthSelectHigh} = 5'h00;
    {autoStopOnFull, pllFactorSelectLow, pllFactorSelectHigh} = 3'b000;
    {edgeTestIsMid, edgeTestIsLow} = 2'b00;
    {countOn, clear} = 2'b00;
    fixedSample = 8'h00;
    tick(6);
    rst <= 1'b0;
    runClk <= 1'b0;
    tick(6);
    check(emptyFlag === 1'b1 && fullFlag === 1'b0, "reset flags");
    check(outputDataStrobe === 1'b0, "strobe idle level");
    t_bypass;
    t_capture(2'b01, 1'b0, 256, 0);
    t_capture(2'b10, 1'b1, 512, 1);
    t_capture(2'b11, 1'b1, 1024, 0);
    t_sleep;
    t_test;
    t_pll;
    tally_and_finish;
  end
  initial
  begin
    tick(40000);
    fails++;
    $display("mismatch at %0t: watchdog expired", $time);
    tally_and_finish;
  end
endmodule
